// *** dpg_pkg.sv ***
// dual port gpio package: register map, reset values, edge codes
// What this block does
// - port data register, writes drive pins, reads return gated input, resets zero
// - direction register, one means output, resets zero
// - pull-up enable, active only in input mode
// - pull-down enable register, resets zero
// - port A input enables reset 8'hF9 (bits 1,2 fixed zero), gate input
// - port A pins 0,4 enables gate interrupts
// - port B input enables gate input, wake, interrupt
// - first source edge field bits 1-0
// - second source edge field bits 3-2
// - selected edge sets sticky request flag
package dpg_pkg;
    localparam logic [7:0] ADDR_EDGE_SEL = 8'h0C;
    localparam logic [7:0] ADDR_PA_IEN = 8'h0D;
    localparam logic [7:0] ADDR_PB_IEN = 8'h0E;
    localparam logic [7:0] ADDR_PA_DATA = 8'h10;
    localparam logic [7:0] ADDR_PA_DIR = 8'h11;
    localparam logic [7:0] ADDR_PA_PU = 8'h12;
    localparam logic [7:0] ADDR_PA_PD = 8'h13;
    localparam logic [7:0] ADDR_PB_DATA = 8'h15;
    localparam logic [7:0] ADDR_PB_DIR = 8'h16;
    localparam logic [7:0] ADDR_PB_PU = 8'h17;
    localparam logic [7:0] ADDR_PB_PD = 8'h18;
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [7:0] RST_PA_IEN = 8'hF9;
    localparam logic [7:0] RST_PB_IEN = 8'hFF;
    localparam logic [7:0] PA_IEN_IMPL = 8'hF9;
    localparam logic [1:0] RST_EDGE = 2'h0;
    localparam int EDGE1_LSB = 0;
    localparam int EDGE2_LSB = 2;
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
endpackage

// *** dpg_edge_det.sv ***
// edge detector for one pin interrupt source
`timescale 1ns/10ps
module dpg_edge_det
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic level,
    input wire logic enable,
    input wire logic [1:0] mode,
    output logic hit
);
    logic prev_q;
    logic prev_d;
    logic hit_q;
    logic hit_d;

    always_comb
    begin
        prev_d = level;
        hit_d = 1'b0;
        if (enable)
        begin
            unique case (mode)
                dpg_pkg::EDGE_BOTH: hit_d = level ^ prev_q;
                dpg_pkg::EDGE_RISE: hit_d = level & ~prev_q;
                dpg_pkg::EDGE_FALL: hit_d = ~level & prev_q;
                default: hit_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prev_q <= 1'b0;
            hit_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
            hit_q <= hit_d;
        end
    end

    assign hit = hit_q;

    a_rise_only: assert property (@(posedge clk) disable iff (sys_rst)
        enable && mode == dpg_pkg::EDGE_RISE && $fell(level) |=> !hit)
        else $error("rise mode fired on falling edge");
    a_fall_fires: assert property (@(posedge clk) disable iff (sys_rst)
        enable && mode == dpg_pkg::EDGE_FALL && $fell(level)
        && $past(enable) |=> hit)
        else $error("fall edge missed");
endmodule

// *** dpg_gpio.sv ***
// dual 8-bit gpio port with input gating and pin edge requests
`timescale 1ns/10ps
module dpg_gpio
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [7:0] io_rdata,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_a_pu,
    output logic [7:0] port_a_pd,
    output logic [7:0] port_a_wake_en,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic [7:0] port_b_pu,
    output logic [7:0] port_b_pd,
    output logic [7:0] port_b_wake_en,
    input wire logic src1_sel_b,
    input wire logic src2_sel_a,
    input wire logic [1:0] irq_clr,
    output logic [1:0] irq_req
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [7:0] a_data_q, a_data_d, a_dir_q, a_dir_d;
    logic [7:0] a_pu_q, a_pu_d, a_pd_q, a_pd_d;
    logic [7:0] b_data_q, b_data_d, b_dir_q, b_dir_d;
    logic [7:0] b_pu_q, b_pu_d, b_pd_q, b_pd_d;
    logic [7:0] a_ien_q, a_ien_d, b_ien_q, b_ien_d;
    logic [3:0] edge_q, edge_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;
    logic [7:0] a_gated, b_gated;
    logic [1:0] irq_q, irq_d;
    logic [1:0] hit;
    logic src1_lvl, src2_lvl, src1_en, src2_en;

    function automatic logic [7:0] wr_reg(input logic [7:0] cur,
        input logic [7:0] a);
        wr_reg = (io_wr && io_addr == a) ? io_wdata : cur;
    endfunction

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_comb
    begin
        a_data_d = wr_reg(a_data_q, dpg_pkg::ADDR_PA_DATA);
        b_data_d = wr_reg(b_data_q, dpg_pkg::ADDR_PB_DATA);
        a_dir_d = wr_reg(a_dir_q, dpg_pkg::ADDR_PA_DIR);
        b_dir_d = wr_reg(b_dir_q, dpg_pkg::ADDR_PB_DIR);
        a_pu_d = wr_reg(a_pu_q, dpg_pkg::ADDR_PA_PU);
        b_pu_d = wr_reg(b_pu_q, dpg_pkg::ADDR_PB_PU);
        a_pd_d = wr_reg(a_pd_q, dpg_pkg::ADDR_PA_PD);
        b_pd_d = wr_reg(b_pd_q, dpg_pkg::ADDR_PB_PD);
        a_ien_d = wr_reg(a_ien_q, dpg_pkg::ADDR_PA_IEN)
            & dpg_pkg::PA_IEN_IMPL;
        b_ien_d = wr_reg(b_ien_q, dpg_pkg::ADDR_PB_IEN);
        edge_d = edge_q;
        if (io_wr && io_addr == dpg_pkg::ADDR_EDGE_SEL)
        begin
            edge_d = io_wdata[3:0];
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb
    begin
        rdata_d = rdata_q;
        if (io_rd)
        begin
            unique case (io_addr)
                dpg_pkg::ADDR_PA_DATA: rdata_d = a_gated;
                dpg_pkg::ADDR_PB_DATA: rdata_d = b_gated;
                dpg_pkg::ADDR_PA_DIR: rdata_d = a_dir_q;
                dpg_pkg::ADDR_PB_DIR: rdata_d = b_dir_q;
                dpg_pkg::ADDR_PA_PU: rdata_d = a_pu_q;
                dpg_pkg::ADDR_PB_PU: rdata_d = b_pu_q;
                dpg_pkg::ADDR_PA_PD: rdata_d = a_pd_q;
                dpg_pkg::ADDR_PB_PD: rdata_d = b_pd_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // input sync and gating
    // ----------------------------------------
    // input path gated
    assign a_gated = a_s2_q & a_ien_q;
    assign b_gated = b_s2_q & b_ien_q;

    assign src1_lvl = src1_sel_b ? b_s2_q[5] : a_s2_q[0];
    assign src2_lvl = src2_sel_a ? a_s2_q[4] : b_s2_q[0];
    assign src1_en = src1_sel_b ? b_ien_q[5] : a_ien_q[0];
    assign src2_en = src2_sel_a ? a_ien_q[4] : b_ien_q[0];

    dpg_edge_det u_edge1
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(src1_lvl),
        .enable(src1_en),
        .mode(edge_q[dpg_pkg::EDGE1_LSB +: 2]),
        .hit(hit[0])
    );

    dpg_edge_det u_edge2
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(src2_lvl),
        .enable(src2_en),
        .mode(edge_q[dpg_pkg::EDGE2_LSB +: 2]),
        .hit(hit[1])
    );

    // ----------------------------------------
    // request flags
    // ----------------------------------------
    always_comb
    begin
        irq_d = (irq_q & ~irq_clr) | hit;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            a_data_q <= dpg_pkg::RST_PORT;
            a_dir_q <= dpg_pkg::RST_PORT;
            a_pu_q <= dpg_pkg::RST_PORT;
            a_pd_q <= dpg_pkg::RST_PORT;
            b_data_q <= dpg_pkg::RST_PORT;
            b_dir_q <= dpg_pkg::RST_PORT;
            b_pu_q <= dpg_pkg::RST_PORT;
            b_pd_q <= dpg_pkg::RST_PORT;
            a_ien_q <= dpg_pkg::RST_PA_IEN;
            b_ien_q <= dpg_pkg::RST_PB_IEN;
            edge_q <= {dpg_pkg::RST_EDGE, dpg_pkg::RST_EDGE};
            rdata_q <= 8'h00;
            irq_q <= 2'h0;
            a_s1_q <= 8'h00;
            a_s2_q <= 8'h00;
            b_s1_q <= 8'h00;
            b_s2_q <= 8'h00;
            port_a_out <= 8'h00;
            port_a_oe <= 8'h00;
            port_a_pu <= 8'h00;
            port_a_pd <= 8'h00;
            port_a_wake_en <= dpg_pkg::RST_PA_IEN;
            port_b_out <= 8'h00;
            port_b_oe <= 8'h00;
            port_b_pu <= 8'h00;
            port_b_pd <= 8'h00;
            port_b_wake_en <= dpg_pkg::RST_PB_IEN;
        end
        else
        begin
            a_data_q <= a_data_d;
            a_dir_q <= a_dir_d;
            a_pu_q <= a_pu_d;
            a_pd_q <= a_pd_d;
            b_data_q <= b_data_d;
            b_dir_q <= b_dir_d;
            b_pu_q <= b_pu_d;
            b_pd_q <= b_pd_d;
            a_ien_q <= a_ien_d;
            b_ien_q <= b_ien_d;
            edge_q <= edge_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            a_s1_q <= port_a_in;
            a_s2_q <= a_s1_q;
            b_s1_q <= port_b_in;
            b_s2_q <= b_s1_q;
            port_a_out <= a_data_d;
            port_a_oe <= a_dir_d;
            port_b_out <= b_data_d;
            port_b_oe <= b_dir_d;
            port_a_pu <= a_pu_d & ~a_dir_d;
            port_b_pu <= b_pu_d & ~b_dir_d;
            port_a_pd <= a_pd_d;
            port_b_pd <= b_pd_d;
            port_a_wake_en <= a_ien_d;
            port_b_wake_en <= b_ien_d;
        end
    end

    assign io_rdata = rdata_q;
    assign irq_req = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // flag one sticky
    a_flag_sticky: assert property (
        @(posedge clk) disable iff (sys_rst)
        irq_q[0] && !irq_clr[0] |=> irq_q[0])
        else $error("request flag dropped without clear");
    a_flag_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        irq_q[1] && !irq_clr[1] |=> irq_q[1])
        else $error("second flag dropped without clear");
    a_flag_sets: assert property (
        @(posedge clk) disable iff (sys_rst)
        hit[1] |=> irq_q[1])
        else $error("request flag not set by edge");
    a_flag_first: assert property (
        @(posedge clk) disable iff (sys_rst)
        hit[0] |=> irq_q[0])
        else $error("first flag not set by edge");
    a_flag_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        irq_q[0] && irq_clr[0] && !hit[0] |=> !irq_q[0])
        else $error("request flag not cleared");
    a_pu_input: assert property (
        @(posedge clk) disable iff (sys_rst)
        (port_a_pu & port_a_oe) == 8'h00)
        else $error("pull-up active on output pin");
    a_pu_input_b: assert property (
        @(posedge clk) disable iff (sys_rst)
        (port_b_pu & port_b_oe) == 8'h00)
        else $error("pull-up active on port b output pin");
    a_oe_dir: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PB_DIR |=>
        port_b_oe == $past(io_wdata))
        else $error("direction write not applied");
    a_oe_dir_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PA_DIR |=>
        port_a_oe == $past(io_wdata))
        else $error("port a direction write not applied");
    a_out_data: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PA_DATA |=>
        port_a_out == $past(io_wdata))
        else $error("data write not driven");
    a_out_data_b: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PB_DATA |=>
        port_b_out == $past(io_wdata))
        else $error("port b data write not driven");
    a_read_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_rd && io_addr == dpg_pkg::ADDR_PA_DATA |=>
        (io_rdata & ~$past(a_ien_q)) == 8'h00)
        else $error("disabled pin read nonzero");
    a_read_gate_b: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_rd && io_addr == dpg_pkg::ADDR_PB_DATA |=>
        (io_rdata & ~$past(b_ien_q)) == 8'h00)
        else $error("disabled port b pin read nonzero");
    a_pd_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PB_PD |=>
        port_b_pd == $past(io_wdata))
        else $error("pull-down write lost");
    a_pd_write_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PA_PD |=>
        port_a_pd == $past(io_wdata))
        else $error("port a pull-down write lost");
    a_rsvd_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        (port_a_wake_en & ~dpg_pkg::PA_IEN_IMPL) == 8'h00)
        else $error("reserved enable bits set");
    a_ien_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PA_IEN |=>
        port_a_wake_en == ($past(io_wdata) & dpg_pkg::PA_IEN_IMPL))
        else $error("port a enable write lost");
    a_ien_write_b: assert property (
        @(posedge clk) disable iff (sys_rst)
        io_wr && io_addr == dpg_pkg::ADDR_PB_IEN |=>
        port_b_wake_en == $past(io_wdata))
        else $error("port b enable write lost");
    a_src_block: assert property (
        @(posedge clk) disable iff (sys_rst)
        !src1_en [*2] |-> !hit[0])
        else $error("disabled source raised request");
    a_src2_block: assert property (
        @(posedge clk) disable iff (sys_rst)
        !src2_en [*2] |-> !hit[1])
        else $error("disabled second source raised request");
    a_rsvd_code1: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(edge_q[1:0]) == 2'h3 |-> !hit[0])
        else $error("reserved edge code raised first request");
    a_rsvd_code2: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(edge_q[3:2]) == 2'h3 |-> !hit[1])
        else $error("reserved edge code raised second request");
    c_flag0: cover property (@(posedge clk) $rose(irq_q[0]));
    c_flag1: cover property (@(posedge clk) $rose(irq_q[1]));
    c_clr_set: cover property (@(posedge clk) irq_clr[0] && hit[0]);
    c_out_mode: cover property (@(posedge clk) port_b_oe == 8'hFF);
endmodule

// *** dpg_pin_model.sv ***
// pin-side circuitry model for one 8-bit port
`timescale 1ns/10ps
module dpg_pin_model
(
    input wire logic clk,
    input wire logic [7:0] drv,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    input wire logic [7:0] pd,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin
);
    // ----------------
    // floating pattern
    // ----------------
    logic [7:0] float_q = 8'h55;
    always_ff @(posedge clk)
        float_q <= ~float_q;
    always_comb
        for (int i = 0; i < 8; i++)
            pin[i] = oe[i] ? drv[i] : ext_en[i] ? ext_val[i] :
                     pu[i] ? 1'b1 : pd[i] ? 1'b0 : float_q[i];
endmodule

// *** tb_top.sv ***
// self-checking bench for the dual port gpio
`timescale 1ns/10ps
module tb_top;
    logic clk, sys_rst, io_wr, io_rd, src1_sel_b, src2_sel_a, rd_pend;
    logic [7:0] io_addr, io_wdata, io_rdata, pa_in, pb_in, b, d, v, en;
    logic [7:0] pa_out, pa_oe, pa_pu, pa_pd, pa_wk;
    logic [7:0] pb_out, pb_oe, pb_pu, pb_pd, pb_wk;
    logic [7:0] pa_ev, pa_ee, pb_ev, pb_ee;
    logic [1:0] irq_clr, irq_req;
    logic [7:0] exp_q[$];
    logic [7:0] zr[10] = '{8'h0C, 8'h0D, 8'h0E, 8'h14, 8'h11, 8'h12,
                           8'h13, 8'h16, 8'h17, 8'h18};
    int num_errors, tests_run, cyc;
    // ----------------
    // instances
    // ----------------
    dpg_gpio dut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .port_a_in(pa_in), .port_a_out(pa_out),
        .port_a_oe(pa_oe), .port_a_pu(pa_pu), .port_a_pd(pa_pd),
        .port_a_wake_en(pa_wk), .port_b_in(pb_in), .port_b_out(pb_out),
        .port_b_oe(pb_oe), .port_b_pu(pb_pu), .port_b_pd(pb_pd),
        .port_b_wake_en(pb_wk), .src1_sel_b(src1_sel_b),
        .src2_sel_a(src2_sel_a), .irq_clr(irq_clr), .irq_req(irq_req));
    dpg_pin_model ma (.clk(clk), .drv(pa_out), .oe(pa_oe), .pu(pa_pu),
        .pd(pa_pd), .ext_val(pa_ev), .ext_en(pa_ee), .pin(pa_in));
    dpg_pin_model mb (.clk(clk), .drv(pb_out), .oe(pb_oe), .pu(pb_pu),
        .pd(pb_pd), .ext_val(pb_ev), .ext_en(pb_ee), .pin(pb_in));
    // ----------------
    // tasks
    // ----------------
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge clk);
        io_addr = a;
        io_wdata = w;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        io_rd = 1'b0;
    endtask
    task automatic clr;
        @(negedge clk);
        irq_clr = 2'b11;
        @(negedge clk);
        irq_clr = 2'b00;
        compare({6'h00, irq_req}, 8'h00);
    endtask
    task test_done;
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------
    // clock, monitor, timeout
    // ----------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        rd_pend <= io_rd & ~sys_rst;
    always @(negedge clk)
        if (rd_pend === 1'b1)
            compare(io_rdata, exp_q.pop_front());
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            test_done;
        end
    end
    // ----------------
    // main sequence
    // ----------------
    initial
    begin
        {io_wr, io_rd, src1_sel_b, src2_sel_a} = 4'h0;
        {io_addr, io_wdata, pa_ev, pb_ev} = 32'h0000_0000;
        {pa_ee, pb_ee, irq_clr} = 18'h3FFFC;
        num_errors = 0;
        tests_run = 0;
        cyc = 0;
        sys_rst = 1'b1;
        void'($urandom(32'hE6A0));
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        compare(pa_out | pb_out, 8'h00);
        compare(pa_oe | pb_oe | pa_pu | pb_pu, 8'h00);
        compare(pa_pd | pb_pd, 8'h00);
        compare(pa_wk, 8'hF9);
        compare(pb_wk, 8'hFF);
        compare({6'h00, irq_req}, 8'h00);
        foreach (zr[i])
            rd(zr[i], 8'h00);
        $display("test reset done");
        for (int p = 0; p < 2; p++)
        begin
            b = p ? 8'h15 : 8'h10;
            v = $urandom;
            wr(b, v);
            compare(p ? pb_out : pa_out, v);
            d = $urandom;
            wr(b + 8'h01, d);
            rd(b + 8'h01, d);
            compare(p ? pb_oe : pa_oe, d);
            v = $urandom;
            wr(b + 8'h02, v);
            rd(b + 8'h02, v);
            compare(p ? pb_pu : pa_pu, v & ~d);
            v = $urandom;
            wr(b + 8'h03, v);
            rd(b + 8'h03, v);
            compare(p ? pb_pd : pa_pd, v);
        end
        $display("test registers done");
        wr(8'h11, 8'h00);
        wr(8'h16, 8'h00);
        wr(8'h12, 8'h00);
        wr(8'h17, 8'h00);
        pa_ev = $urandom;
        pb_ev = $urandom;
        repeat (3) @(negedge clk);
        rd(8'h10, pa_ev & 8'hF9);
        rd(8'h15, pb_ev);
        en = $urandom & 8'h39;
        wr(8'h0D, en);
        compare(pa_wk, en);
        v = $urandom;
        wr(8'h0E, v);
        compare(pb_wk, v);
        repeat (3) @(negedge clk);
        rd(8'h10, pa_ev & en);
        rd(8'h15, pb_ev & v);
        pb_ee = 8'h00;
        pa_ee = 8'h00;
        wr(8'h16, 8'hFF);
        d = $urandom;
        wr(8'h15, d);
        wr(8'h12, 8'hFF);
        repeat (3) @(negedge clk);
        rd(8'h15, d & v);
        rd(8'h10, en);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'hFF);
        repeat (3) @(negedge clk);
        rd(8'h10, 8'h00);
        $display("test pins done");
        {pa_ev, pb_ev, pa_ee, pb_ee} = 32'h0000_FFFF;
        wr(8'h0D, 8'hF9);
        wr(8'h0E, 8'hFF);
        wr(8'h16, 8'h00);
        repeat (6) @(negedge clk);
        clr();
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
            begin
                src1_sel_b = s[0];
                src2_sel_a = s[0];
                wr(8'h0C, {4'h0, m[1:0], m[1:0]});
                pa_ev = 8'h11;
                pb_ev = 8'h21;
                repeat (8) @(negedge clk);
                compare({6'h00, irq_req}, (m < 2) ? 8'h03 : 8'h00);
                clr();
                {pa_ev, pb_ev} = 16'h0000;
                repeat (8) @(negedge clk);
                compare({6'h00, irq_req}, (m % 2 == 0 && m < 3) ?
                    8'h03 : 8'h00);
                clr();
            end
        $display("test edges done");
        wr(8'h0C, 8'h00);
        wr(8'h0D, 8'hE8);
        wr(8'h0E, 8'hDE);
        pa_ev = 8'h11;
        pb_ev = 8'h21;
        repeat (8) @(negedge clk);
        compare({6'h00, irq_req}, 8'h00);
        $display("test gating done");
        test_done;
    end
endmodule
